/* File: rtl/fault_select_pkg.sv */
// Package holding register map, field layout and reset values of the fault source selector.
package fault_select_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  // ==========================================================================
  localparam logic [31:0] CH1_IDE_SOURCE_ENABLE_OFFSET = 32'h0003_0050;
  localparam logic [31:0] CH2_CURRENT_LIMIT_SOURCE_ENABLE_OFFSET = 32'h0003_0054;
  localparam logic [31:0] CH2_FAULT_AB_SOURCE_ENABLE_OFFSET = 32'h0003_0058;
  localparam logic [31:0] STATUS_OFFSET = 32'h0003_0060;

  // ==========================================================================
  // Source counts and field positions.
  // ==========================================================================
  localparam int ANALOG_CMP_COUNT = 7;
  localparam int DIGITAL_CMP_COUNT = 4;
  localparam int EXT_PIN_COUNT = 4;

  localparam int IDE_WIDTH = 7;
  localparam int CLIM_WIDTH = 17;
  localparam int FLTAB_WIDTH = 15;

  localparam int IDE_ANALOG_LSB = 0;
  localparam int CLIM_ANALOG_LSB = 0;
  localparam int CLIM_PIN_LSB = 7;
  localparam int CLIM_UNUSED_BIT = 11;
  localparam int CLIM_DIGITAL_LSB = 12;
  localparam int CLIM_PEAK_BIT = 16;
  localparam int FLTAB_ANALOG_LSB = 0;
  localparam int FLTAB_PIN_LSB = 7;
  localparam int FLTAB_DIGITAL_LSB = 11;

  // Writable bits of the current-limit register; bit 11 reads as zero.
  localparam logic [16:0] CLIM_WRITE_MASK = 17'h1F7FF;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [6:0] IDE_RESET = 7'h00;
  localparam logic [16:0] CLIM_RESET = 17'h00000;
  localparam logic [14:0] FLTAB_RESET = 15'h0000;

endpackage : fault_select_pkg

/* File: rtl/source_combiner.sv */
// Masked OR of a group of source results into one registered trigger.
`timescale 1ns/1ps
module source_combiner #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] sources,
  input wire logic [WIDTH-1:0] enables,
  output logic trigger
);

  always_ff @(posedge clk) begin
    if (rst) begin
      trigger <= 1'b0;
    end else begin
      trigger <= |(sources & enables);
    end
  end

endmodule : source_combiner

/* File: rtl/fault_source_select.sv */
// Top of the fault source selector: Wishbone register bank and three trigger combiners.
`timescale 1ns/1ps
module fault_source_select (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire logic [6:0] ANALOG_CMP,
  input wire logic [3:0] DIGITAL_CMP,
  input wire logic [3:0] EXT_FAULT_PIN,
  input wire logic ANALOG_PEAK_CURRENT,
  output logic IDLE_EDGE_TRIGGER,
  output logic CURRENT_LIMIT_TRIGGER,
  output logic FAULT_AB_TRIGGER
);

  // ==========================================================================
  // Registers and bus decode.
  // ==========================================================================
  logic [6:0] ide_analog_en_reg;
  logic [6:0] clim_analog_en_reg;
  logic [3:0] clim_pin_en_reg;
  logic [3:0] clim_digital_en_reg;
  logic clim_peak_en_reg;
  logic [6:0] fltab_analog_en_reg;
  logic [3:0] fltab_pin_en_reg;
  logic [3:0] fltab_digital_en_reg;
  logic [6:0] ide_word;
  logic [16:0] clim_word;
  logic [14:0] fltab_word;
  logic [6:0] ide_sources;
  logic write_ide;
  logic write_clim;
  logic write_fltab;
  logic read_mapped;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic [6:0] analog_reg;
  logic [3:0] digital_reg;
  logic [3:0] pin_reg;
  logic peak_reg;
  logic req;
  logic hit_ide;
  logic hit_clim;
  logic hit_fltab;
  logic hit_status;
  logic mapped;
  logic [31:0] byte_mask;
  logic [31:0] wr_merge_ide;
  logic [31:0] wr_merge_clim;
  logic [31:0] wr_merge_fltab;
  logic [31:0] read_value;
  logic [16:0] clim_sources;
  logic [14:0] fltab_sources;

  // A new request is taken only while no answer is pending, so every access gets exactly one ack or err.
  assign req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
  assign hit_ide = WB_ADR_I == fault_select_pkg::CH1_IDE_SOURCE_ENABLE_OFFSET;
  assign hit_clim = WB_ADR_I == fault_select_pkg::CH2_CURRENT_LIMIT_SOURCE_ENABLE_OFFSET;
  assign hit_fltab = WB_ADR_I == fault_select_pkg::CH2_FAULT_AB_SOURCE_ENABLE_OFFSET;
  assign hit_status = WB_ADR_I == fault_select_pkg::STATUS_OFFSET;
  assign mapped = hit_ide || hit_clim || hit_fltab || hit_status;

  // ==========================================================================
  // Write and read strobes.
  // ==========================================================================
  // Strobes last only for the one cycle in which a request is taken.
  assign write_ide = req && WB_WE_I && hit_ide;
  assign write_clim = req && WB_WE_I && hit_clim;
  assign write_fltab = req && WB_WE_I && hit_fltab;
  assign read_mapped = req && mapped && !WB_WE_I;

  // ==========================================================================
  // Byte-lane merge.
  // ==========================================================================
  // Lanes that are not selected keep their contents, so software may update one byte alone.
  assign byte_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wr_merge_ide = (WB_DAT_I & byte_mask) | ({25'h0000000, ide_word} & ~byte_mask);
  assign wr_merge_clim = (WB_DAT_I & byte_mask) | ({15'h0000, clim_word} & ~byte_mask);
  assign wr_merge_fltab = (WB_DAT_I & byte_mask) | ({17'h00000, fltab_word} & ~byte_mask);

  // ==========================================================================
  // Enable fields, one flop group for each source group.
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (RST) begin
      ide_analog_en_reg <= fault_select_pkg::IDE_RESET[fault_select_pkg::IDE_ANALOG_LSB +: 7];
    end else if (write_ide) begin
      ide_analog_en_reg <= wr_merge_ide[fault_select_pkg::IDE_ANALOG_LSB +: 7];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      clim_analog_en_reg <= fault_select_pkg::CLIM_RESET[fault_select_pkg::CLIM_ANALOG_LSB +: 7];
    end else if (write_clim) begin
      clim_analog_en_reg <= wr_merge_clim[fault_select_pkg::CLIM_ANALOG_LSB +: 7];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      clim_pin_en_reg <= fault_select_pkg::CLIM_RESET[fault_select_pkg::CLIM_PIN_LSB +: 4];
    end else if (write_clim) begin
      clim_pin_en_reg <= wr_merge_clim[fault_select_pkg::CLIM_PIN_LSB +: 4];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      clim_digital_en_reg <= fault_select_pkg::CLIM_RESET[fault_select_pkg::CLIM_DIGITAL_LSB +: 4];
    end else if (write_clim) begin
      clim_digital_en_reg <= wr_merge_clim[fault_select_pkg::CLIM_DIGITAL_LSB +: 4];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      clim_peak_en_reg <= fault_select_pkg::CLIM_RESET[fault_select_pkg::CLIM_PEAK_BIT];
    end else if (write_clim) begin
      clim_peak_en_reg <= wr_merge_clim[fault_select_pkg::CLIM_PEAK_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fltab_analog_en_reg <= fault_select_pkg::FLTAB_RESET[fault_select_pkg::FLTAB_ANALOG_LSB +: 7];
    end else if (write_fltab) begin
      fltab_analog_en_reg <= wr_merge_fltab[fault_select_pkg::FLTAB_ANALOG_LSB +: 7];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fltab_pin_en_reg <= fault_select_pkg::FLTAB_RESET[fault_select_pkg::FLTAB_PIN_LSB +: 4];
    end else if (write_fltab) begin
      fltab_pin_en_reg <= wr_merge_fltab[fault_select_pkg::FLTAB_PIN_LSB +: 4];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fltab_digital_en_reg <= fault_select_pkg::FLTAB_RESET[fault_select_pkg::FLTAB_DIGITAL_LSB +: 4];
    end else if (write_fltab) begin
      fltab_digital_en_reg <= wr_merge_fltab[fault_select_pkg::FLTAB_DIGITAL_LSB +: 4];
    end
  end

  // ==========================================================================
  // Register words as software sees them.
  // ==========================================================================
  always_comb begin
    ide_word = '0;
    ide_word[fault_select_pkg::IDE_ANALOG_LSB +: 7] = ide_analog_en_reg;
  end

  // The unused current-limit bit has no flop, so writes to it are lost and it reads as zero.
  always_comb begin
    clim_word = '0;
    clim_word[fault_select_pkg::CLIM_ANALOG_LSB +: 7] = clim_analog_en_reg;
    clim_word[fault_select_pkg::CLIM_PIN_LSB +: 4] = clim_pin_en_reg;
    clim_word[fault_select_pkg::CLIM_UNUSED_BIT] = 1'b0;
    clim_word[fault_select_pkg::CLIM_DIGITAL_LSB +: 4] = clim_digital_en_reg;
    clim_word[fault_select_pkg::CLIM_PEAK_BIT] = clim_peak_en_reg;
  end

  always_comb begin
    fltab_word = '0;
    fltab_word[fault_select_pkg::FLTAB_ANALOG_LSB +: 7] = fltab_analog_en_reg;
    fltab_word[fault_select_pkg::FLTAB_PIN_LSB +: 4] = fltab_pin_en_reg;
    fltab_word[fault_select_pkg::FLTAB_DIGITAL_LSB +: 4] = fltab_digital_en_reg;
  end

  // ==========================================================================
  // Read data.
  // ==========================================================================
  always_comb begin
    read_value = 32'h00000000;
    if (hit_ide) begin
      read_value = {25'h0000000, ide_word};
    end else if (hit_clim) begin
      read_value = {15'h0000, clim_word};
    end else if (hit_fltab) begin
      read_value = {17'h00000, fltab_word};
    end else if (hit_status) begin
      read_value = {29'h00000000, FAULT_AB_TRIGGER, CURRENT_LIMIT_TRIGGER, IDLE_EDGE_TRIGGER};
    end
  end

  // ==========================================================================
  // Bus answers.
  // ==========================================================================
  // Answers come one cycle after the request and drop the cycle after, because a
  // request is taken only while no answer is pending.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && mapped;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= req && !mapped;
    end
  end

  // Read data stands until the next mapped read, so a slow master can still pick it up.
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= 32'h00000000;
    end else if (read_mapped) begin
      rdata_reg <= read_value;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_ERR_O = err_reg;
  assign WB_DAT_O = rdata_reg;

  // ==========================================================================
  // Source sampling.
  // ==========================================================================
  // Every source passes one flop before it is combined; this costs a cycle of
  // latency but keeps input timing out of the trigger paths.
  always_ff @(posedge CLK) begin
    if (RST) begin
      analog_reg <= 7'h00;
    end else begin
      analog_reg <= ANALOG_CMP;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      digital_reg <= 4'h0;
    end else begin
      digital_reg <= DIGITAL_CMP;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_reg <= 4'h0;
    end else begin
      pin_reg <= EXT_FAULT_PIN;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      peak_reg <= 1'b0;
    end else begin
      peak_reg <= ANALOG_PEAK_CURRENT;
    end
  end

  // ==========================================================================
  // Source vectors.
  // ==========================================================================
  // Source vectors line up bit for bit with the enable words; the unused
  // current-limit position is tied low so it can never select anything.
  always_comb begin
    ide_sources = '0;
    ide_sources[fault_select_pkg::IDE_ANALOG_LSB +: 7] = analog_reg;
  end

  always_comb begin
    clim_sources = '0;
    clim_sources[fault_select_pkg::CLIM_ANALOG_LSB +: 7] = analog_reg;
    clim_sources[fault_select_pkg::CLIM_PIN_LSB +: 4] = pin_reg;
    clim_sources[fault_select_pkg::CLIM_UNUSED_BIT] = 1'b0;
    clim_sources[fault_select_pkg::CLIM_DIGITAL_LSB +: 4] = digital_reg;
    clim_sources[fault_select_pkg::CLIM_PEAK_BIT] = peak_reg;
  end

  always_comb begin
    fltab_sources = '0;
    fltab_sources[fault_select_pkg::FLTAB_ANALOG_LSB +: 7] = analog_reg;
    fltab_sources[fault_select_pkg::FLTAB_PIN_LSB +: 4] = pin_reg;
    fltab_sources[fault_select_pkg::FLTAB_DIGITAL_LSB +: 4] = digital_reg;
  end

  // ==========================================================================
  // Trigger combiners.
  // ==========================================================================
  // Each trigger is registered once more after the masked OR, so the protection
  // logic sees a glitch-free level two cycles after a source changes.
  source_combiner #(
    .WIDTH(fault_select_pkg::IDE_WIDTH)
  ) ide_combiner (
    .clk(CLK),
    .rst(RST),
    .sources(ide_sources),
    .enables(ide_word),
    .trigger(IDLE_EDGE_TRIGGER)
  );

  source_combiner #(
    .WIDTH(fault_select_pkg::CLIM_WIDTH)
  ) clim_combiner (
    .clk(CLK),
    .rst(RST),
    .sources(clim_sources),
    .enables(clim_word),
    .trigger(CURRENT_LIMIT_TRIGGER)
  );

  source_combiner #(
    .WIDTH(fault_select_pkg::FLTAB_WIDTH)
  ) fltab_combiner (
    .clk(CLK),
    .rst(RST),
    .sources(fltab_sources),
    .enables(fltab_word),
    .trigger(FAULT_AB_TRIGGER)
  );

endmodule : fault_source_select

/* File: verification/source_model.sv */
// Model of the comparator and fault pin results that feed the selector.
`timescale 1ns/1ps
module source_model (
  input wire logic clk,
  input wire logic [15:0] pattern,
  output logic [15:0] results
);
  // Results move just after an edge, as the comparator flops they stand for do.
  always @(posedge clk) results <= pattern;
endmodule : source_model

/* File: verification/fault_select_sva.sv */
// Checker of the bus answers and trigger outputs of the selector.
`timescale 1ns/1ps
module fault_select_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic [6:0] ANALOG_CMP,
  input wire logic [3:0] DIGITAL_CMP,
  input wire logic [3:0] EXT_FAULT_PIN,
  input wire logic ANALOG_PEAK_CURRENT,
  input wire logic IDLE_EDGE_TRIGGER,
  input wire logic CURRENT_LIMIT_TRIGGER,
  input wire logic FAULT_AB_TRIGGER
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic req;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  // ==========
  // Properties
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  err_pulse_a: assert property (WB_ERR_O |=> !WB_ERR_O) else $error("err too long");
  answer_time_a: assert property (req |=> WB_ACK_O || WB_ERR_O) else $error("no answer");
  no_cause_a: assert property ((WB_ACK_O || WB_ERR_O) |-> $past(req)) else $error("answer uncaused");
  one_answer_a: assert property (!(WB_ACK_O && WB_ERR_O)) else $error("ack with err");
  map_ack_a: assert property (req && WB_ADR_I inside {32'h00030050, 32'h00030054, 32'h00030058, 32'h00030060}
    |=> WB_ACK_O)
    else $error("mapped not acked");
  ide_quiet_a: assert property ((ANALOG_CMP == 7'h00) [*2] |=> !IDLE_EDGE_TRIGGER) else $error("ide fired");
  fab_quiet_a: assert property (
    ({DIGITAL_CMP, EXT_FAULT_PIN, ANALOG_CMP} == 15'h0000) [*2] |=> !FAULT_AB_TRIGGER)
    else $error("fault ab fired");
  clim_quiet_a: assert property (
    ({ANALOG_PEAK_CURRENT, DIGITAL_CMP, EXT_FAULT_PIN, ANALOG_CMP} == 16'h0000) [*2] |=> !CURRENT_LIMIT_TRIGGER)
    else $error("current limit fired");
  ack_c: cover property (WB_ACK_O);
  clim_c: cover property (CURRENT_LIMIT_TRIGGER);
  err_c: cover property (WB_ERR_O);
  ide_c: cover property (IDLE_EDGE_TRIGGER);
endmodule : fault_select_sva

/* File: verification/tb_top.sv */
// Self-checking testbench of the fault source selector.
`timescale 1ns/1ps
`define CHK(n,e,g) begin check_count++; if ((g)!==(e)) begin errors++; $display("mismatch %s exp %h got %h",n,e,g); end end
module tb_top;
  localparam logic [31:0] BASE = fault_select_pkg::CH1_IDE_SOURCE_ENABLE_OFFSET;
  logic CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, e;
  logic [3:0] WB_SEL_I = 4'hF;
  logic [31:0] WB_ADR_I = '0, WB_DAT_I = '0, WB_DAT_O, q;
  logic [15:0] pat = '0;
  wire logic [6:0] ANALOG_CMP;
  wire logic [3:0] DIGITAL_CMP, EXT_FAULT_PIN;
  wire logic ANALOG_PEAK_CURRENT;
  logic WB_ACK_O, WB_ERR_O, IDLE_EDGE_TRIGGER, CURRENT_LIMIT_TRIGGER, FAULT_AB_TRIGGER;
  wire [2:0] trig = {IDLE_EDGE_TRIGGER, CURRENT_LIMIT_TRIGGER, FAULT_AB_TRIGGER};
  logic [31:0] full [3] = '{32'h0000007F, 32'h0001F7FF, 32'h00007FFF};
  int errors = 0, check_count = 0, c;
  fault_source_select uut (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O,
    .WB_ACK_O, .WB_ERR_O, .ANALOG_CMP, .DIGITAL_CMP, .EXT_FAULT_PIN, .ANALOG_PEAK_CURRENT, .IDLE_EDGE_TRIGGER,
    .CURRENT_LIMIT_TRIGGER, .FAULT_AB_TRIGGER);
  source_model far (.clk(CLK), .pattern(pat),
    .results({ANALOG_PEAK_CURRENT, DIGITAL_CMP, EXT_FAULT_PIN, ANALOG_CMP}));
  initial forever #4 CLK = ~CLK;
  // ==========
  // Bus access
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, w, a, d};
    do @(posedge CLK); while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && ++n < 20);
    if (n == 20) errors++;
    q = WB_DAT_O;
    e = WB_ERR_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    @(posedge CLK);
  endtask : bus
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, BASE + 32'(4 * k), '0);
      `CHK("reset", 32'h0, q)
      bus(1'b1, BASE + 32'(4 * k), '1);
      bus(1'b0, BASE + 32'(4 * k), '0);
      `CHK("ones", full[k], q)
    end
    bus(1'b0, BASE + 32'hC, '0);
    `CHK("unmapped", 1'b1, e)
    bus(1'b1, BASE + 32'h4, 32'h00000800);
    pat <= '1;
    repeat (4) @(posedge CLK);
    `CHK("bit 11", 1'b0, CURRENT_LIMIT_TRIGGER)
    bus(1'b0, BASE + 32'h10, '0);
    `CHK("status", 32'h00000005, q)
    WB_SEL_I <= 4'h4;
    bus(1'b1, BASE + 32'h4, '1);
    WB_SEL_I <= 4'hF;
    bus(1'b0, BASE + 32'h4, '0);
    `CHK("lane", 32'h00010000, q)
    // Peak current has no Fault AB bit and digital bits sit one higher in the current-limit word.
    for (int i = 0; i < 16; i++) begin
      c = (i < 11) ? i : ((i < 15) ? i + 1 : 16);
      bus(1'b1, BASE, 32'(i < 7) << i);
      bus(1'b1, BASE + 32'h4, 32'h1 << c);
      bus(1'b1, BASE + 32'h8, 32'(i < 15) << i);
      pat <= 16'h1 << i;
      repeat (4) @(posedge CLK);
      `CHK("on", {i < 7, 1'b1, i < 15}, trig)
      pat <= ~(16'h1 << i);
      repeat (4) @(posedge CLK);
      `CHK("off", 3'b000, trig)
    end
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge CLK);
    errors++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
endmodule : tb_top
bind fault_source_select fault_select_sva chk (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_ADR_I, .WB_ACK_O, .WB_ERR_O,
  .ANALOG_CMP, .DIGITAL_CMP, .EXT_FAULT_PIN, .ANALOG_PEAK_CURRENT, .IDLE_EDGE_TRIGGER, .CURRENT_LIMIT_TRIGGER,
  .FAULT_AB_TRIGGER);
